// >>> hdl/pae_defines.svh
// Register offsets, field positions, reset values and timing for the alarm evaluator
`ifndef PAE_DEFINES_SVH
`define PAE_DEFINES_SVH

// Register byte offsets
`define PAE_CTRL_OFS        8'h00
`define PAE_STATUS_OFS      8'h04
`define PAE_RATE_OFS        8'h08
`define PAE_ALM_BASE_IDX    4'h1
`define PAE_ALM_LAST_IDX    4'h4
`define PAE_ALM_CFG_WORD    2'h0
`define PAE_ALM_HI_WORD     2'h1
`define PAE_ALM_LO_WORD     2'h2

// Control register fields
`define PAE_CTRL_HEATCOOL   0
`define PAE_CTRL_REMOTE     1
`define PAE_CTRL_SPSEL      2
`define PAE_CTRL_SBRESET    3

// Alarm configuration register fields
`define PAE_CFG_TYPE_MSB    4
`define PAE_CFG_LATCH       8
`define PAE_CFG_HDEF        9
`define PAE_CFG_HYST_LSB    16

// Reset values, default hysteresis bands and rate period limits
`define PAE_CTRL_RST        4'h0
`define PAE_TYPE_RST        5'h02
`define PAE_VALUE_RST       16'h000a
`define PAE_HYST_TEMP       16'h0002
`define PAE_HYST_MV         16'h0032
`define PAE_RATE_RST        10'h014
`define PAE_RATE_MIN        10'h001
`define PAE_RATE_MAX        10'h3e7

// Sampling period and clock
`define PAE_SAMPLE_NS       50000000
`define PAE_CLK_NS          40

`endif

// >>> hdl/pae_pkg.sv
// Types shared by the alarm evaluator files
package pae_pkg;

    // Alarm type codes as set by the operator
    typedef enum logic [4:0] {
        PAE_AT_OFF       = 5'h00,
        PAE_AT_UL        = 5'h01,
        PAE_AT_UP        = 5'h02,
        PAE_AT_LO        = 5'h03,
        PAE_AT_RANGE     = 5'h04,
        PAE_AT_UL_SB     = 5'h05,
        PAE_AT_UP_SB     = 5'h06,
        PAE_AT_LO_SB     = 5'h07,
        PAE_AT_ABS_UP    = 5'h08,
        PAE_AT_ABS_LO    = 5'h09,
        PAE_AT_ABS_UP_SB = 5'h0a,
        PAE_AT_ABS_LO_SB = 5'h0b,
        PAE_AT_LOOP      = 5'h0c,
        PAE_AT_RATE      = 5'h0d,
        PAE_AT_SP_UP     = 5'h0e,
        PAE_AT_SP_LO     = 5'h0f,
        PAE_AT_MV_UP     = 5'h10,
        PAE_AT_MV_LO     = 5'h11,
        PAE_AT_RT_UP     = 5'h12,
        PAE_AT_RT_LO     = 5'h13
    } pae_alarm_type_t;

    // Values supplied by the control loop
    typedef struct packed {
        logic signed [15:0] process_value;
        logic signed [15:0] ramp_sp;
        logic signed [15:0] target_sp;
        logic signed [15:0] mv_heat;
        logic signed [15:0] mv_cool;
        logic signed [15:0] remote_target;
    } pae_loop_t;

    // Per-alarm configuration
    typedef struct packed {
        logic [15:0]     hyst;
        logic            hyst_default;
        logic            latch_en;
        pae_alarm_type_t alarm_type;
    } pae_alarm_cfg_t;

endpackage : pae_pkg

// >>> hdl/pae_hyst_cmp.sv
// One-sided threshold comparator with hysteresis
`timescale 1ns/1ps
`default_nettype none

module pae_hyst_cmp #(
    parameter int W = 18
) (
    input  wire logic signed [W-1:0] value,
    input  wire logic signed [W-1:0] threshold,
    input  wire logic [15:0]         hyst,
    input  wire logic                upper_dir,
    input  wire logic                state_q,
    output logic                     state_d
);

    logic signed [W-1:0] h_ext;
    logic signed [W-1:0] off_hi;
    logic signed [W-1:0] off_lo;

    // Release point sits one hysteresis band inside the trip point
    assign h_ext  = $signed({{(W-16){1'b0}}, hyst});
    assign off_hi = threshold - h_ext;
    assign off_lo = threshold + h_ext;

    // Trip beyond threshold, release past band, hold between
    always_comb begin
        if (upper_dir) begin
            if (value > threshold) state_d = 1'b1;
            else if (value < off_hi) state_d = 1'b0;
            else state_d = state_q;
        end else begin
            if (value < threshold) state_d = 1'b1;
            else if (value > off_lo) state_d = 1'b0;
            else state_d = state_q;
        end
    end

endmodule : pae_hyst_cmp

`default_nettype wire

// >>> hdl/pae_alarm_eval.sv
// Four-channel process alarm evaluator with APB register access
// Summary of operation
// - Types 1, 4, 5 use separate upper and lower alarm values.
// - Type 5 output stays off when upper and lower bands overlap.
// - Heat/cool: output high alarm uses heat output, low uses cool.
// - Each period, rate alarm compares current minus previous value.
// - Rate period in 50 ms samples, 1 to 999, default 20.
// - Positive rate value detects rises, negative detects falls.
// - Set-point alarms select ramping or final target set point.
// - Set-point, output, remote alarms use alarm value and hysteresis.
// - Every alarm has its own hysteresis setting.
// - Default hysteresis 0.2 deg or 0.02% FS; output alarms 0.50%.
// - Standby suppresses alarm until value leaves then re-enters region.
// - Standby ends on alarm output; re-armed per standby reset setting.
// - Latched output stays on until a latch clear.
// - Latch clears at power-down and on entry to setting levels.
// - Latch also clears from function key or event input.
// - Remote alarms work only with remote input fitted.
// - Absolute upper alarm trips when process value exceeds value.
// - Set-point high alarm trips when set point exceeds value.
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pae_defines.svh"

module pae_alarm_eval #(
    parameter int NUM_ALARMS    = 4,
    parameter int SAMPLE_CYCLES = `PAE_SAMPLE_NS / `PAE_CLK_NS
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire pae_pkg::pae_loop_t loop_in,
    input  wire logic              level_entry,
    input  wire logic              function_key,
    input  wire logic              event_input,
    output logic [NUM_ALARMS-1:0]  alarm_out
);

    typedef logic signed [17:0] val_t;

    // Register state
    logic [3:0]                ctrl_q;
    logic [9:0]                rate_per_q;
    pae_pkg::pae_alarm_cfg_t   cfg_q [NUM_ALARMS];
    logic signed [15:0]        hi_q  [NUM_ALARMS];
    logic signed [15:0]        lo_q  [NUM_ALARMS];
    logic [31:0]               prdata_q;
    logic [31:0]               rd_data;

    // Evaluation state
    logic [31:0]               tick_cnt_q;
    logic                      tick;
    logic [9:0]                rate_cnt_q;
    logic                      rate_end;
    logic signed [15:0]        rate_prev_q;
    val_t                      rate_diff_q;
    logic [2:0]                key_sync_q;
    logic [2:0]                evt_sync_q;
    logic                      latch_clr;
    logic                      rearm;
    logic [NUM_ALARMS-1:0]     up_q, up_d, lo_q_st, lo_d, pend_q, out_d, raw, eval;

    // Bus decode
    logic       acc, wr_en, ctrl_hit, stat_hit, rate_hit, alm_hit;
    logic [3:0] alm_idx;
    logic [1:0] alm_word;
    logic [9:0] rate_wr;
    assign alm_idx  = paddr[7:4] - `PAE_ALM_BASE_IDX;
    assign alm_word = paddr[3:2];
    assign ctrl_hit = paddr == `PAE_CTRL_OFS;
    assign stat_hit = paddr == `PAE_STATUS_OFS;
    assign rate_hit = paddr == `PAE_RATE_OFS;
    assign alm_hit  = paddr[7:4] >= `PAE_ALM_BASE_IDX && paddr[7:4] <= `PAE_ALM_LAST_IDX
                      && paddr[1:0] == 2'h0 && alm_word != 2'h3;
    assign acc      = psel & penable;
    assign wr_en    = acc & pwrite;
    assign pready   = 1'b1;
    assign pslverr  = acc & ~(ctrl_hit | stat_hit | rate_hit | alm_hit);
    assign prdata   = prdata_q;
    // Out-of-range periods are pinned rather than refused
    assign rate_wr  = pwdata[9:0] < `PAE_RATE_MIN ? `PAE_RATE_MIN :
                      pwdata[9:0] > `PAE_RATE_MAX ? `PAE_RATE_MAX : pwdata[9:0];

    // Read mux; unmapped reads return zero
    always_comb begin
        rd_data = 32'h0000_0000;
        if (ctrl_hit) rd_data = {28'h0, ctrl_q};
        else if (stat_hit) rd_data = {24'h0, pend_q, alarm_out};
        else if (rate_hit) rd_data = {22'h0, rate_per_q};
        else if (alm_hit) begin
            unique case (alm_word)
                `PAE_ALM_CFG_WORD: rd_data = {cfg_q[alm_idx[1:0]].hyst, 6'h0,
                    cfg_q[alm_idx[1:0]].hyst_default, cfg_q[alm_idx[1:0]].latch_en,
                    3'h0, cfg_q[alm_idx[1:0]].alarm_type};
                `PAE_ALM_HI_WORD:  rd_data = {16'h0, hi_q[alm_idx[1:0]]};
                default:           rd_data = {16'h0, lo_q[alm_idx[1:0]]};
            endcase
        end
    end

    // Read data captured in the setup cycle, valid through access
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) prdata_q <= 32'h0000_0000;
        else if (psel && !penable && !pwrite) prdata_q <= rd_data;
    end

    // Global control and rate period registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q     <= `PAE_CTRL_RST;
            rate_per_q <= `PAE_RATE_RST;
        end else if (wr_en && ctrl_hit) ctrl_q <= pwdata[3:0];
        else if (wr_en && rate_hit) rate_per_q <= rate_wr;
    end

    // Per-alarm configuration and value registers
    generate
        for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_regs
            logic sel;
            assign sel = wr_en && alm_hit && alm_idx == 4'(g);
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cfg_q[g] <= '{`PAE_HYST_TEMP, 1'b1, 1'b0,
                                  pae_pkg::pae_alarm_type_t'(`PAE_TYPE_RST)};
                    hi_q[g]  <= `PAE_VALUE_RST;
                    lo_q[g]  <= `PAE_VALUE_RST;
                end else if (sel && alm_word == `PAE_ALM_CFG_WORD) begin
                    cfg_q[g] <= '{pwdata[31:16], pwdata[`PAE_CFG_HDEF], pwdata[`PAE_CFG_LATCH],
                        pae_pkg::pae_alarm_type_t'(pwdata[`PAE_CFG_TYPE_MSB:0])};
                end else if (sel && alm_word == `PAE_ALM_HI_WORD) hi_q[g] <= pwdata[15:0];
                else if (sel && alm_word == `PAE_ALM_LO_WORD) lo_q[g] <= pwdata[15:0];
            end
        end
    endgenerate

    // Sampling tick, one per 50 ms sampling period
    assign tick = tick_cnt_q == 32'(SAMPLE_CYCLES - 1);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) tick_cnt_q <= 32'h0;
        else tick_cnt_q <= tick ? 32'h0 : tick_cnt_q + 32'h1;
    end

    // Rate of change: difference over the programmed number of samples
    assign rate_end = tick && rate_cnt_q >= rate_per_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_cnt_q  <= 10'h001;
            rate_prev_q <= 16'sh0000;
            rate_diff_q <= 18'sh00000;
        end else if (rate_end) begin
            rate_cnt_q  <= 10'h001;
            rate_prev_q <= loop_in.process_value;
            rate_diff_q <= val_t'(loop_in.process_value) - val_t'(rate_prev_q);
        end else if (tick) rate_cnt_q <= rate_cnt_q + 10'h001;
    end

    // Pins are synchronised; the edge detector reads only later stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            key_sync_q <= 3'h0;
            evt_sync_q <= 3'h0;
        end else begin
            key_sync_q <= {key_sync_q[1:0], function_key};
            evt_sync_q <= {evt_sync_q[1:0], event_input};
        end
    end
    assign latch_clr = level_entry
                       | (key_sync_q[1] & ~key_sync_q[2])
                       | (evt_sync_q[1] & ~evt_sync_q[2]);
    // Standby reset setting 0 re-arms on latch clears, 1 only at power-up
    assign rearm = latch_clr & ~ctrl_q[`PAE_CTRL_SBRESET];

    // Type decoding shared by all channels
    function automatic logic is_sb(input pae_pkg::pae_alarm_type_t t);
        return t inside {pae_pkg::PAE_AT_UL_SB, pae_pkg::PAE_AT_UP_SB, pae_pkg::PAE_AT_LO_SB,
                         pae_pkg::PAE_AT_ABS_UP_SB, pae_pkg::PAE_AT_ABS_LO_SB};
    endfunction : is_sb
    function automatic logic is_dev(input pae_pkg::pae_alarm_type_t t);
        return t inside {[pae_pkg::PAE_AT_UL:pae_pkg::PAE_AT_LO_SB]};
    endfunction : is_dev
    function automatic logic is_lower(input pae_pkg::pae_alarm_type_t t);
        return t inside {pae_pkg::PAE_AT_LO, pae_pkg::PAE_AT_LO_SB, pae_pkg::PAE_AT_ABS_LO,
                         pae_pkg::PAE_AT_ABS_LO_SB, pae_pkg::PAE_AT_SP_LO,
                         pae_pkg::PAE_AT_MV_LO, pae_pkg::PAE_AT_RT_LO};
    endfunction : is_lower

    val_t sp_sel;
    // Set-point alarms watch the ramping or the final set point
    assign sp_sel = ctrl_q[`PAE_CTRL_SPSEL] ? val_t'(loop_in.target_sp)
                                            : val_t'(loop_in.ramp_sp);

    // Channel evaluation
    generate
        for (genvar g = 0; g < NUM_ALARMS; g++) begin : g_alm
            pae_pkg::pae_alarm_type_t t;
            logic [15:0] hy;
            logic        mv_t, rt_t, pair_t, ovl, up_dir_lo;
            val_t        mon, th_hi, th_lo;
            assign t    = cfg_q[g].alarm_type;
            assign mv_t = t inside {pae_pkg::PAE_AT_MV_UP, pae_pkg::PAE_AT_MV_LO};
            assign rt_t = t inside {pae_pkg::PAE_AT_RT_UP, pae_pkg::PAE_AT_RT_LO};
            assign pair_t = t inside {pae_pkg::PAE_AT_UL, pae_pkg::PAE_AT_RANGE,
                                      pae_pkg::PAE_AT_UL_SB};
            // Default band is 0.2 deg / 0.02% FS, output alarms 0.50%
            assign hy = !cfg_q[g].hyst_default ? cfg_q[g].hyst
                        : mv_t ? `PAE_HYST_MV : `PAE_HYST_TEMP;

            // Monitored quantity per type
            always_comb begin
                unique case (t)
                    pae_pkg::PAE_AT_SP_UP, pae_pkg::PAE_AT_SP_LO: mon = sp_sel;
                    pae_pkg::PAE_AT_MV_UP: mon = val_t'(loop_in.mv_heat);
                    pae_pkg::PAE_AT_MV_LO: mon = ctrl_q[`PAE_CTRL_HEATCOOL]
                        ? val_t'(loop_in.mv_cool) : val_t'(loop_in.mv_heat);
                    pae_pkg::PAE_AT_RT_UP, pae_pkg::PAE_AT_RT_LO:
                        mon = val_t'(loop_in.remote_target);
                    pae_pkg::PAE_AT_RATE: mon = rate_diff_q;
                    default: mon = is_dev(t) ? val_t'(loop_in.process_value) - sp_sel
                                             : val_t'(loop_in.process_value);
                endcase
            end

            // Deviation lower limits sit below the set point
            assign th_hi = val_t'(hi_q[g]);
            assign th_lo = !is_dev(t) ? val_t'(hi_q[g])
                         : pair_t ? -val_t'(lo_q[g]) : -val_t'(hi_q[g]);
            // A negative rate value watches for a falling process value
            assign up_dir_lo = t == pae_pkg::PAE_AT_RATE && hi_q[g] >= 16'sh0000;
            // Bands overlap when upper release falls under lower release
            assign ovl = val_t'(hi_q[g]) + val_t'(lo_q[g]) < val_t'({hy, 1'b0});

            pae_hyst_cmp #(.W(18)) u_up (
                .value     (mon),
                .threshold (th_hi),
                .hyst      (hy),
                .upper_dir (1'b1),
                .state_q   (up_q[g]),
                .state_d   (up_d[g])
            );
            pae_hyst_cmp #(.W(18)) u_lo (
                .value     (mon),
                .threshold (th_lo),
                .hyst      (hy),
                .upper_dir (up_dir_lo),
                .state_q   (lo_q_st[g]),
                .state_d   (lo_d[g])
            );

            // Raw condition before standby and latch
            always_comb begin
                if (pair_t) raw[g] = t == pae_pkg::PAE_AT_RANGE ? ~(up_d[g] | lo_d[g])
                                                                : up_d[g] | lo_d[g];
                else if (t == pae_pkg::PAE_AT_RATE) raw[g] = lo_d[g];
                else if (is_lower(t)) raw[g] = lo_d[g];
                else raw[g] = up_d[g] && t != pae_pkg::PAE_AT_OFF
                              && t != pae_pkg::PAE_AT_LOOP && t <= pae_pkg::PAE_AT_RT_LO;
            end
            assign eval[g] = raw[g]
                & ~(is_sb(t) & pend_q[g])
                & ~(t == pae_pkg::PAE_AT_UL_SB & ovl)
                & ~(rt_t & ~ctrl_q[`PAE_CTRL_REMOTE]);
            // A clear in a sampling cycle loses to a fresh alarm
            assign out_d[g] = tick ? eval[g] | (cfg_q[g].latch_en & alarm_out[g] & ~latch_clr)
                                   : alarm_out[g] & ~(cfg_q[g].latch_en & latch_clr);

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    up_q[g]    <= 1'b0;
                    lo_q_st[g] <= 1'b0;
                    pend_q[g]  <= 1'b1;
                    alarm_out[g] <= 1'b0;
                end else begin
                    alarm_out[g] <= out_d[g];
                    if (tick) begin
                        up_q[g]    <= up_d[g];
                        lo_q_st[g] <= lo_d[g];
                    end
                    if (rearm) pend_q[g] <= 1'b1;
                    else if (tick && (!raw[g] || eval[g])) pend_q[g] <= 1'b0;
                end
            end

            // Checks on each channel
            sequence s_latched;
                cfg_q[g].latch_en && alarm_out[g] && !latch_clr;
            endsequence
            chk_overlap_off: assert property (@(posedge pclk) disable iff (!presetn)
                tick && t == pae_pkg::PAE_AT_UL_SB && ovl && !cfg_q[g].latch_en
                |=> !alarm_out[g]) else $error("overlapping bands gave output");
            chk_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
                s_latched |=> alarm_out[g]) else $error("latched alarm dropped");
            chk_latch_clear: assert property (@(posedge pclk) disable iff (!presetn)
                cfg_q[g].latch_en && latch_clr && !tick |=> !alarm_out[g])
                else $error("latch clear ignored");
            chk_abs_upper: assert property (@(posedge pclk) disable iff (!presetn)
                tick && t == pae_pkg::PAE_AT_ABS_UP && loop_in.process_value > hi_q[g]
                |=> alarm_out[g]) else $error("absolute upper alarm missed");
            chk_sp_high: assert property (@(posedge pclk) disable iff (!presetn)
                tick && t == pae_pkg::PAE_AT_SP_UP && sp_sel > val_t'(hi_q[g])
                |=> alarm_out[g]) else $error("set-point high alarm missed");
            chk_remote_absent: assert property (@(posedge pclk) disable iff (!presetn)
                tick && rt_t && !ctrl_q[`PAE_CTRL_REMOTE] && !cfg_q[g].latch_en
                |=> !alarm_out[g]) else $error("remote alarm without input");
            chk_standby_hold: assert property (@(posedge pclk) disable iff (!presetn)
                tick && is_sb(t) && pend_q[g] && !cfg_q[g].latch_en && !rearm
                |=> !alarm_out[g]) else $error("standby alarm leaked");
        end
    endgenerate

    // Rate difference renews exactly at a period end, counter restarts at one
    sequence s_rate_end;
        rate_end ##1 rate_cnt_q == 10'h001;
    endsequence
    chk_rate_period: assert property (@(posedge pclk) disable iff (!presetn)
        rate_end |-> s_rate_end) else $error("rate period did not restart");
    chk_rate_diff: assert property (@(posedge pclk) disable iff (!presetn)
        rate_end |=> rate_diff_q == val_t'($past(loop_in.process_value))
                      - val_t'($past(rate_prev_q))) else $error("rate difference wrong");

endmodule : pae_alarm_eval

`default_nettype wire

// >>> dv/pae_loop_model.sv
// Control loop model feeding measured, target and output values to the evaluator
`timescale 1ns/1ps
`default_nettype none

module pae_loop_model (
    input  wire logic signed [15:0] pv,
    input  wire logic signed [15:0] sp,
    input  wire logic signed [15:0] mv,
    input  wire logic               pclk,
    output pae_pkg::pae_loop_t      loop_out
);
    // Final target sits 200 above the ramp, cooling mirrors heating, so each selection shows
    always_ff @(posedge pclk) begin
        loop_out <= '{pv, sp, sp + 16'sh00c8, mv, -mv, sp};
    end
endmodule : pae_loop_model

`default_nettype wire

// >>> dv/pae_alarm_eval_tb.sv
// Self-checking bench for the alarm evaluator
`timescale 1ns/1ps
`default_nettype none

module pae_alarm_eval_tb;
    typedef struct packed {
        logic [3:0] c;
        logic [4:0] t;
        logic [15:0] v, p, s, m;
        logic e;
    } pae_row_t;
    localparam int TICK = 8;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, level_entry = 1'b0, function_key = 1'b0, event_input = 1'b0;
    logic signed [15:0] pv = 16'sh0, sp = 16'sh0, mv = 16'sh0;
    pae_pkg::pae_loop_t loop_in;
    logic [3:0] alarm_out;
    int bad_count = 0, n_checks = 0, cycles = 0;
    // Control, type, value, process, set point, output, expected alarm 0
    pae_row_t rows [18] = '{
        '{4'h0, 5'h08, 16'h0064, 16'h0096, 16'h0, 16'h0, 1'b1}, '{4'h0, 5'h08, 16'h0064,
        16'h0062, 16'h0, 16'h0, 1'b1}, '{4'h0, 5'h08, 16'h0064, 16'h0032, 16'h0, 16'h0, 1'b0},
        '{4'h0, 5'h09, 16'h0064, 16'h0032, 16'h0, 16'h0, 1'b1}, '{4'h0, 5'h02, 16'h000a,
        16'h0014, 16'h0, 16'h0, 1'b1}, '{4'h0, 5'h03, 16'h000a, 16'hffec, 16'h0, 16'h0, 1'b1},
        '{4'h0, 5'h0e, 16'h0064, 16'h0, 16'h0096, 16'h0, 1'b1}, '{4'h0, 5'h0e, 16'h0064,
        16'h0, 16'h0, 16'h0, 1'b0}, '{4'h0, 5'h10, 16'h001e, 16'h0, 16'h0, 16'h0032, 1'b1},
        '{4'h0, 5'h11, 16'h001e, 16'h0, 16'h0, 16'h0032, 1'b0}, '{4'h0, 5'h12, 16'hff9c,
        16'h0, 16'h0, 16'h0, 1'b0}, '{4'h0, 5'h01, 16'h000a, 16'h0014, 16'h0, 16'h0, 1'b1},
        '{4'h0, 5'h04, 16'h000a, 16'h0, 16'h0, 16'h0, 1'b1}, '{4'h0, 5'h05, 16'h0001, 16'h0014,
        16'h0, 16'h0, 1'b0}, '{4'h0, 5'h00, 16'h0064, 16'h0096, 16'h0, 16'h0, 1'b0}, '{4'h2,
        5'h12, 16'hff9c, 16'h0, 16'h0, 16'h0, 1'b1}, '{4'h6, 5'h0e, 16'h0064, 16'h0, 16'h0,
        16'h0, 1'b1}, '{4'h1, 5'h11, 16'h0000, 16'h0, 16'h0, 16'h0032, 1'b1}};

    pae_alarm_eval #(.SAMPLE_CYCLES(TICK)) pae_alarm_eval_inst (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .loop_in(loop_in),
        .level_entry(level_entry), .function_key(function_key), .event_input(event_input),
        .alarm_out(alarm_out));
    pae_loop_model pae_loop_model_inst (.pv(pv), .sp(sp), .mv(mv), .pclk(pclk),
        .loop_out(loop_in));

    always #20 pclk = ~pclk;

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : complete_run

    // Hang guard well above the roughly 1,200 cycles the sequence needs
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            complete_run();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    // One APB transfer; idles an edge after so back-to-back calls never double-drive psel
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask : rdchk

    // Alarm 0 with explicit hysteresis of 4, lower value equal to upper
    task automatic arm(input logic [4:0] t, input logic l, input logic [15:0] v);
        apb(1'b1, 8'h10, {16'h0004, 6'h00, 1'b0, l, 3'h0, t});
        apb(1'b1, 8'h14, {16'h0000, v});
        apb(1'b1, 8'h18, {16'h0000, v});
    endtask : arm

    task automatic ticks(input int n);
        repeat (n * TICK + 2) @(posedge pclk);
    endtask : ticks

    // Pulse one clear source long enough to pass the pin synchronisers
    task automatic clear_pin(input int s);
        function_key <= (s == 0);
        event_input <= (s == 1);
        level_entry <= (s == 2);
        repeat (3) @(posedge pclk);
        function_key <= 1'b0;
        event_input <= 1'b0;
        level_entry <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : clear_pin

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(8'h00, 32'h0);
        rdchk(8'h08, 32'h14);
        rdchk(8'h10, 32'h00020202);
        rdchk(8'h14, 32'h0000000a);
        rdchk(8'h0c, 32'h0);
        check({31'h0, err}, 32'h1);
        for (int i = 0; i < 18; i++) begin
            pv <= rows[i].p;
            sp <= rows[i].s;
            mv <= rows[i].m;
            apb(1'b1, 8'h00, {28'h0, rows[i].c});
            arm(rows[i].t, 1'b0, rows[i].v);
            ticks(3);
            check({31'h0, alarm_out[0]}, {31'h0, rows[i].e});
        end
        for (int s = 0; s < 3; s++) begin
            arm(5'h08, 1'b1, 16'h0064);
            pv <= 16'sh0096;
            ticks(3);
            pv <= 16'sh0032;
            ticks(3);
            check({31'h0, alarm_out[0]}, 32'h1);
            clear_pin(s);
            check({31'h0, alarm_out[0]}, 32'h0);
        end
        apb(1'b1, 8'h08, 32'h0);
        rdchk(8'h08, 32'h1);
        apb(1'b1, 8'h08, 32'h3e8);
        rdchk(8'h08, 32'h3e7);
        apb(1'b1, 8'h08, 32'h1);
        arm(5'h0d, 1'b1, 16'h0014);
        pv <= 16'sh0;
        ticks(3);
        clear_pin(0);
        pv <= 16'sh0064;
        ticks(3);
        check({31'h0, alarm_out[0]}, 32'h1);
        arm(5'h0d, 1'b1, 16'hffec);
        clear_pin(0);
        pv <= 16'sh00c8;
        ticks(3);
        check({31'h0, alarm_out[0]}, 32'h0);
        pv <= 16'sh0;
        ticks(3);
        check({31'h0, alarm_out[0]}, 32'h1);
        arm(5'h0a, 1'b0, 16'h0064);
        pv <= 16'sh0096;
        clear_pin(0);
        ticks(3);
        check({31'h0, alarm_out[0]}, 32'h0);
        pv <= 16'sh0032;
        ticks(3);
        pv <= 16'sh0096;
        ticks(3);
        check({31'h0, alarm_out[0]}, 32'h1);
        complete_run();
    end
endmodule : pae_alarm_eval_tb

`default_nettype wire
